// *** src/decider_pkg.sv ***
package decider_pkg;

	// ****************************************************************
	// Register map, byte addresses, one word each
	// ****************************************************************
	localparam logic [7:0] ADDR_CONFIG = 8'h00;
	localparam logic [7:0] ADDR_DOWN_DELAY = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	localparam logic [7:0] ADDR_BND_HIGH = 8'h10;
	localparam logic [7:0] ADDR_BND_LOW = 8'h20;
	localparam logic [7:0] ADDR_TARGET = 8'h40;
	localparam logic [7:0] ADDR_TARGET_END = 8'h7c;

	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int CFG_ENABLE_BIT = 0;
	localparam int CFG_ALGO_BIT = 1;
	localparam int CFG_PSEL_LSB = 2;
	localparam int ST_APPLIED_LSB = 0;
	localparam int ST_AVG_LSB = 4;
	localparam int ST_FAST_BIT = 8;
	localparam int ST_CONF_BIT = 9;
	localparam int ST_DIR_LSB = 10;
	localparam int ST_COUNT_LSB = 12;

	// ****************************************************************
	// Sizes and reset values
	// ****************************************************************
	localparam int NUM_BOUNDS = 4;
	localparam int NUM_ZONES = 5;
	localparam int NUM_BANKS = 3;
	localparam int NUM_TARGETS = 15;
	localparam logic [7:0] BND_HIGH_RST [4] = '{8'h35, 8'h6a, 8'ha1, 8'hdc};
	localparam logic [7:0] BND_LOW_RST [4] = '{8'h33, 8'h66, 8'h99, 8'hcc};
	localparam logic [7:0] TARGET_RST [5] = '{8'h33, 8'h66, 8'h99, 8'hcc,
		8'hff};
	localparam logic [4:0] DOWN_DELAY_RST = 5'h00;
	localparam logic [2:0] PSEL_RST = 3'h0;
	localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam real CLK_PERIOD_NS = 25.0;
	localparam real FAST_PERIOD_MS = 1.1;
	localparam int FAST_PERIOD_CYCLES = int'(FAST_PERIOD_MS * 1.0e6 /
		CLK_PERIOD_NS);
	localparam logic [1:0] FAST_PERIODS = 2'h3;
	localparam logic [5:0] CONFIRM_PERIODS = 6'h03;
	localparam logic [5:0] DOWN_EXTRA_BASE = 6'h03;

	typedef logic [2:0] zone_t;
	typedef enum logic [1:0] {DIR_NONE, DIR_UP, DIR_DOWN} dir_t;

endpackage : decider_pkg

// *** src/decider_if.sv ***
`timescale 1ns/100ps
`default_nettype none

// Period timing between the decider and its timer
interface period_if;
	logic start;
	logic enable;
	logic [2:0] period_sel;
	logic period_end;
	logic fast_active;
	modport timer(input start, enable, period_sel,
		output period_end, fast_active);
	modport user(output start, enable, period_sel,
		input period_end, fast_active);
endinterface : period_if

// Averaged sums and thresholds for zone classification
interface zone_if import decider_pkg::*;;
	logic [23:0] sum;
	logic [15:0] count;
	zone_t prev_zone;
	zone_t new_zone;
	logic [7:0] high [4];
	logic [7:0] low [4];
	modport classifier(input sum, count, prev_zone, high, low,
		output new_zone);
	modport user(output sum, count, prev_zone, high, low,
		input new_zone);
endinterface : zone_if

`default_nettype wire

// *** src/period_timer.sv ***
`timescale 1ns/100ps
`default_nettype none

module period_timer import decider_pkg::*; #(
	parameter int FAST_CYCLES = FAST_PERIOD_CYCLES,
	parameter int UNIT_CYCLES = FAST_PERIOD_CYCLES
) (
	input wire logic clock_in, // System clock
	input wire logic reset_in, // Synchronous reset
	period_if.timer tmr // Period timing
);
	logic [31:0] cnt_reg, cnt_next, limit;
	logic [1:0] fcnt_reg, fcnt_next;
	logic fast_reg, fast_next, wrap;

	// Period length and wrap; >= so a shorter new length ends at once
	always_comb begin
		limit = fast_reg ? 32'(FAST_CYCLES) :
			(32'(UNIT_CYCLES) << tmr.period_sel);
		wrap = tmr.enable && (cnt_reg >= limit - 32'h1);
		cnt_next = cnt_reg + 32'h1;
		fast_next = fast_reg;
		fcnt_next = fcnt_reg;
		if (tmr.start) begin
			cnt_next = 32'h0;
			fast_next = 1'b1;
			fcnt_next = 2'h0;
		end else if (!tmr.enable) begin
			cnt_next = 32'h0;
			fast_next = 1'b0;
			fcnt_next = 2'h0;
		end else if (wrap) begin
			cnt_next = 32'h0;
			if (fast_reg) begin
				fcnt_next = fcnt_reg + 2'h1;
				if (fcnt_reg == FAST_PERIODS - 2'h1) begin
					fast_next = 1'b0;
				end
			end
		end
	end

	// State registers
	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			cnt_reg <= 32'h0;
			fcnt_reg <= 2'h0;
			fast_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			fcnt_reg <= fcnt_next;
			fast_reg <= fast_next;
		end
	end

	assign tmr.period_end = wrap && !tmr.start;
	assign tmr.fast_active = fast_reg;

	// ****************************************************************
	// Checks
	// ****************************************************************
	a_fast_len: assert property (@(posedge clock_in) disable iff (reset_in)
		tmr.period_end && fast_reg |-> cnt_reg == 32'(FAST_CYCLES - 1))
		else $error("fast period has wrong length");
	a_fast_three: assert property (@(posedge clock_in) disable iff (reset_in)
		$fell(fast_reg) && $past(tmr.enable) |->
		$past(tmr.period_end) && $past(fcnt_reg) == 2'h2)
		else $error("fast start-up left before third period");

endmodule : period_timer

`default_nettype wire

// *** src/zone_classifier.sv ***
`timescale 1ns/100ps
`default_nettype none

module zone_classifier import decider_pkg::*; (
	zone_if.classifier zc // Sums in, zone out
);
	logic [23:0] bound;
	logic crossed;

	// Below the old zone a boundary stays crossed until under its low
	// threshold; above it, it is crossed only at its high threshold.
	// Comparing sums to threshold times count avoids a divider.
	always_comb begin
		bound = 24'h0;
		crossed = 1'b0;
		zc.new_zone = 3'h0;
		for (int i = 0; i < NUM_BOUNDS; i++) begin
			if (3'(i) < zc.prev_zone) begin
				bound = 24'(zc.low[i]) * 24'(zc.count);
				crossed = !(zc.sum < bound);
			end else begin
				bound = 24'(zc.high[i]) * 24'(zc.count);
				crossed = zc.sum >= bound;
			end
			zc.new_zone = zc.new_zone + 3'(crossed);
		end
		if (zc.count == 16'h0) begin
			zc.new_zone = zc.prev_zone;
		end
	end

endmodule : zone_classifier

`default_nettype wire

// *** src/ambient_zone_backlight_decider.sv ***
`timescale 1ns/100ps
`default_nettype none

module ambient_zone_backlight_decider import decider_pkg::*; #(
	parameter int FAST_CYCLES = FAST_PERIOD_CYCLES, // Fast period length
	parameter int UNIT_CYCLES = FAST_PERIOD_CYCLES // Shortest normal period
) (
	input wire logic clock_in, // 40 MHz clock
	input wire logic reset_in, // Synchronous reset, high
	input wire logic [7:0] avs_address_in, // Byte address
	input wire logic avs_read_in, // Read request
	input wire logic avs_write_in, // Write request
	input wire logic [31:0] avs_writedata_in, // Write data
	output logic [31:0] avs_readdata_out, // Read data
	output logic avs_waitrequest_out, // Stall, low when answered
	input wire logic [7:0] ambient_light_input_sample_in, // Converted sample
	input wire logic ambient_light_input_valid_in, // Sample strobe
	output logic [7:0] bank_a_target_out, // Bank A brightness target
	output logic [7:0] bank_b_target_out, // Bank B brightness target
	output logic [7:0] bank_c_target_out, // Bank C brightness target
	output logic [2:0] applied_zone_out, // Zone driving the targets
	output logic [2:0] averaged_zone_out // Zone of the last full period
);
	// ****************************************************************
	// Helpers
	// ****************************************************************
	function automatic logic [5:0] periods_needed(input dir_t dir,
		input logic down_delay, input logic [4:0] code);
		if (dir == DIR_DOWN && down_delay) begin
			return CONFIRM_PERIODS + DOWN_EXTRA_BASE +
				{1'b0, code};
		end
		return CONFIRM_PERIODS;
	endfunction : periods_needed

	function automatic logic [3:0] target_index(input int bank,
		input zone_t zone);
		return 4'(bank * NUM_ZONES) + {1'b0, zone};
	endfunction : target_index

	// ****************************************************************
	// Declarations
	// ****************************************************************
	logic wait_reg, wait_next;
	logic [31:0] rdata_reg, rdata_next;
	logic enable_reg, enable_next, algo_reg, algo_next;
	logic [2:0] psel_reg, psel_next;
	logic [4:0] code_reg, code_next;
	logic [7:0] high_reg [4];
	logic [7:0] high_next [4];
	logic [7:0] low_reg [4];
	logic [7:0] low_next [4];
	logic [7:0] target_reg [15];
	logic [7:0] target_next [15];
	logic take_wr, take_rd;
	logic [3:0] tidx;

	zone_t az_reg, az_next, applied_reg, applied_next;
	dir_t dir_reg, dir_next;
	logic [5:0] cnt_reg, cnt_next;
	logic conf_reg, conf_next, enable_q_reg;
	logic [23:0] sum_reg, sum_next;
	logic [15:0] n_reg, n_next;
	logic start, pe, fast, up, down;
	zone_t zn;

	logic [7:0] bank_reg [3];

	period_if pif();
	zone_if zif();

	// ****************************************************************
	// Sub-blocks
	// ****************************************************************
	period_timer #(
		.FAST_CYCLES(FAST_CYCLES),
		.UNIT_CYCLES(UNIT_CYCLES)
	) u_timer (
		.clock_in(clock_in),
		.reset_in(reset_in),
		.tmr(pif.timer)
	);

	zone_classifier u_classifier (
		.zc(zif.classifier)
	);

	// Start-up is the rising edge of the enable bit
	assign start = enable_reg && !enable_q_reg;
	assign pif.start = start;
	assign pif.enable = enable_reg;
	assign pif.period_sel = psel_reg;
	assign pe = pif.period_end;
	assign fast = pif.fast_active;
	assign zif.sum = sum_reg;
	assign zif.count = n_reg;
	assign zif.prev_zone = az_reg;
	assign zif.high = high_reg;
	assign zif.low = low_reg;
	assign zn = zif.new_zone;
	assign up = zn > az_reg;
	assign down = zn < az_reg;

	// ****************************************************************
	// Register bus
	// ****************************************************************
	// One stall cycle per request; answer sits in registers meanwhile
	always_comb begin
		take_wr = avs_write_in && !wait_reg;
		take_rd = avs_read_in && !wait_reg;
		wait_next = !((avs_read_in || avs_write_in) && wait_reg);
		enable_next = enable_reg;
		algo_next = algo_reg;
		psel_next = psel_reg;
		code_next = code_reg;
		high_next = high_reg;
		low_next = low_reg;
		target_next = target_reg;
		tidx = 4'((avs_address_in - ADDR_TARGET) >> 2);
		rdata_next = take_rd ? UNMAPPED_DATA : rdata_reg;
		if (avs_address_in[1:0] != 2'h0) begin
			rdata_next = take_rd ? UNMAPPED_DATA : rdata_reg;
		end else if (avs_address_in == ADDR_CONFIG) begin
			if (take_wr) begin
				enable_next = avs_writedata_in[CFG_ENABLE_BIT];
				algo_next = avs_writedata_in[CFG_ALGO_BIT];
				psel_next = avs_writedata_in[CFG_PSEL_LSB +: 3];
			end
			if (avs_read_in && wait_reg) begin
				rdata_next = 32'(psel_reg) << CFG_PSEL_LSB;
				rdata_next[CFG_ALGO_BIT] = algo_reg;
				rdata_next[CFG_ENABLE_BIT] = enable_reg;
			end
		end else if (avs_address_in == ADDR_DOWN_DELAY) begin
			if (take_wr) begin
				code_next = avs_writedata_in[4:0];
			end
			if (avs_read_in && wait_reg) begin
				rdata_next = 32'(code_reg);
			end
		end else if (avs_address_in == ADDR_STATUS) begin
			if (avs_read_in && wait_reg) begin
				rdata_next = (32'(applied_reg) << ST_APPLIED_LSB) |
					(32'(az_reg) << ST_AVG_LSB) |
					(32'(cnt_reg) << ST_COUNT_LSB) |
					(32'(dir_reg) << ST_DIR_LSB);
				rdata_next[ST_FAST_BIT] = fast;
				rdata_next[ST_CONF_BIT] = conf_reg;
			end
		end else if (avs_address_in[7:4] == ADDR_BND_HIGH[7:4]) begin
			if (take_wr) begin
				high_next[avs_address_in[3:2]] = avs_writedata_in[7:0];
			end
			if (avs_read_in && wait_reg) begin
				rdata_next = 32'(high_reg[avs_address_in[3:2]]);
			end
		end else if (avs_address_in[7:4] == ADDR_BND_LOW[7:4]) begin
			if (take_wr) begin
				low_next[avs_address_in[3:2]] = avs_writedata_in[7:0];
			end
			if (avs_read_in && wait_reg) begin
				rdata_next = 32'(low_reg[avs_address_in[3:2]]);
			end
		end else if (avs_address_in >= ADDR_TARGET &&
			avs_address_in < ADDR_TARGET_END) begin
			if (take_wr) begin
				target_next[tidx] = avs_writedata_in[7:0];
			end
			if (avs_read_in && wait_reg) begin
				rdata_next = 32'(target_reg[tidx]);
			end
		end else if (avs_read_in && wait_reg) begin
			rdata_next = UNMAPPED_DATA;
		end
	end

	// Bus and configuration registers
	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			wait_reg <= 1'b1;
			rdata_reg <= UNMAPPED_DATA;
			enable_reg <= 1'b0;
			algo_reg <= 1'b0;
			psel_reg <= PSEL_RST;
			code_reg <= DOWN_DELAY_RST;
			high_reg <= BND_HIGH_RST;
			low_reg <= BND_LOW_RST;
			for (int i = 0; i < NUM_TARGETS; i++) begin
				target_reg[i] <= TARGET_RST[i % NUM_ZONES];
			end
		end else begin
			wait_reg <= wait_next;
			rdata_reg <= rdata_next;
			enable_reg <= enable_next;
			algo_reg <= algo_next;
			psel_reg <= psel_next;
			code_reg <= code_next;
			high_reg <= high_next;
			low_reg <= low_next;
			target_reg <= target_next;
		end
	end

	// ****************************************************************
	// Averaging and zone decision
	// ****************************************************************
	// Counter saturates rather than wraps so a long period stays sane
	always_comb begin
		sum_next = sum_reg;
		n_next = n_reg;
		az_next = az_reg;
		applied_next = applied_reg;
		dir_next = dir_reg;
		cnt_next = cnt_reg;
		conf_next = conf_reg;
		if (enable_reg && ambient_light_input_valid_in &&
			n_reg != 16'hffff) begin
			sum_next = sum_reg + 24'(ambient_light_input_sample_in);
			n_next = n_reg + 16'h1;
		end
		if (start) begin
			sum_next = 24'h0;
			n_next = 16'h0;
			az_next = 3'h0;
			applied_next = 3'h0;
			dir_next = DIR_NONE;
			cnt_next = 6'h0;
			conf_next = 1'b0;
		end else if (pe) begin
			sum_next = 24'h0;
			n_next = 16'h0;
			az_next = zn;
			if (fast) begin
				applied_next = zn;
				dir_next = DIR_NONE;
				cnt_next = 6'h0;
				conf_next = 1'b0;
			end else if (conf_reg && ((up && dir_reg == DIR_UP) ||
				(down && dir_reg == DIR_DOWN))) begin
				applied_next = zn;
			end else begin
				if (conf_reg) begin
					conf_next = 1'b0;
					dir_next = DIR_NONE;
					cnt_next = 6'h0;
				end
				case (dir_next)
					DIR_NONE: begin
						if (up || down) begin
							dir_next = up ? DIR_UP : DIR_DOWN;
							cnt_next = 6'h1;
						end
					end
					DIR_UP: begin
						if (down) begin
							dir_next = DIR_DOWN;
							cnt_next = 6'h1;
						end else if (cnt_next != 6'h3f) begin
							cnt_next = cnt_next + 6'h1;
						end
					end
					DIR_DOWN: begin
						if (up) begin
							dir_next = DIR_UP;
							cnt_next = 6'h1;
						end else if (cnt_next != 6'h3f) begin
							cnt_next = cnt_next + 6'h1;
						end
					end
					default: begin
						dir_next = DIR_NONE;
						cnt_next = 6'h0;
					end
				endcase
				if (dir_next != DIR_NONE &&
					cnt_next == periods_needed(dir_next, algo_reg, code_reg)) begin
					applied_next = zn;
					conf_next = 1'b1;
				end
			end
		end
	end

	// Decision registers
	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			sum_reg <= 24'h0;
			n_reg <= 16'h0;
			az_reg <= 3'h0;
			applied_reg <= 3'h0;
			dir_reg <= DIR_NONE;
			cnt_reg <= 6'h0;
			conf_reg <= 1'b0;
			enable_q_reg <= 1'b0;
		end else begin
			sum_reg <= sum_next;
			n_reg <= n_next;
			az_reg <= az_next;
			applied_reg <= applied_next;
			dir_reg <= dir_next;
			cnt_reg <= cnt_next;
			conf_reg <= conf_next;
			enable_q_reg <= enable_reg;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	// Targets re-registered each cycle so software edits show promptly
	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			for (int b = 0; b < NUM_BANKS; b++) begin
				bank_reg[b] <= TARGET_RST[0];
			end
		end else begin
			for (int b = 0; b < NUM_BANKS; b++) begin
				bank_reg[b] <= target_reg[target_index(b, applied_reg)];
			end
		end
	end

	assign bank_a_target_out = bank_reg[0];
	assign bank_b_target_out = bank_reg[1];
	assign bank_c_target_out = bank_reg[2];
	assign applied_zone_out = applied_reg;
	assign averaged_zone_out = az_reg;
	assign avs_readdata_out = rdata_reg;
	assign avs_waitrequest_out = wait_reg;

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (reset_in);

	a_start_zone_zero: assert property (start |=> applied_reg == 3'h0 && az_reg == 3'h0)
		else $error("start-up did not clear zone");
	a_avg_on_boundary: assert property ($changed(az_reg) |-> $past(pe) || $past(start))
		else $error("averaged zone moved mid-period");
	a_apply_boundary: assert property ($changed(applied_reg) |-> $past(pe) || $past(start))
		else $error("target moved mid-period");
	a_apply_from_zone: assert property ($changed(applied_reg) && !$past(start) |-> applied_reg == az_reg)
		else $error("applied zone differs from averaged zone");
	a_confirm_count: assert property ($rose(conf_reg) |-> cnt_reg == periods_needed(dir_reg, algo_reg, code_reg))
		else $error("confirmation at wrong period count");
	a_hold_clears: assert property (pe && !fast && conf_reg && !up && !down |=> !conf_reg && dir_reg == DIR_NONE)
		else $error("confirmation kept after idle period");
	a_same_follow: assert property (pe && !fast && conf_reg && dir_reg == DIR_UP && up |=> applied_reg == $past(zn))
		else $error("same-direction change not applied");
	a_rise_abandon: assert property (pe && !fast && !conf_reg && dir_reg == DIR_DOWN && up |=> dir_reg == DIR_UP && cnt_reg == 6'h1 && $stable(applied_reg))
		else $error("pending downward move not abandoned");
	a_bus_answer: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out ##1 avs_waitrequest_out)
		else $error("bus answer not one cycle later");

	c_down_delay: cover property ($rose(conf_reg) && dir_reg == DIR_DOWN && algo_reg);
	c_abandon: cover property (pe && !fast && dir_reg == DIR_DOWN && up && algo_reg);
	c_follow: cover property (pe && !fast && conf_reg && down && dir_reg == DIR_DOWN);
	c_fast_done: cover property ($fell(fast));

endmodule : ambient_zone_backlight_decider

`default_nettype wire

// *** verif/sensor_model.sv ***
`timescale 1ns/100ps
`default_nettype none

// ****************************************************************
// Light sensor and converter stand-in
// ****************************************************************
module sensor_model #(
	parameter int GAP = 4 // Cycles between conversions
) (
	input wire logic clock_in, // System clock
	input wire logic [7:0] level_in, // Light level to convert
	output logic [7:0] sample_out, // Converted sample
	output logic valid_out // One-cycle strobe
);
	int cnt = 0;

	// Quiet start, so the strobe is never unknown
	initial begin
		sample_out = 8'h00;
		valid_out = 1'b0;
	end

	// Stale data is inverted so nothing can lean on it between strobes
	always @(posedge clock_in) begin
		cnt <= (cnt == GAP - 1) ? 0 : cnt + 1;
		valid_out <= (cnt == 0);
		sample_out <= (cnt == 0) ? level_in : ~sample_out;
	end
endmodule : sensor_model

`default_nettype wire

// *** verif/tb_ambient_zone_backlight_decider.sv ***
`timescale 1ns/100ps
`default_nettype none

module tb_ambient_zone_backlight_decider import decider_pkg::*;;
	logic clock_in = 1'b0;
	logic reset_in = 1'b1;
	logic [7:0] address = 8'h00;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [31:0] readdata;
	logic [31:0] seen;
	logic waitreq;
	logic [7:0] level = 8'hb0;
	logic [7:0] smp;
	logic vld;
	logic [7:0] ta, tb, tc;
	logic [2:0] az, vz;
	int fails = 0;
	int tests_run = 0;

	// 40 MHz clock
	initial forever #12.5 clock_in = ~clock_in;

	// Short periods: fast 20 cycles, normal 40 cycles
	ambient_zone_backlight_decider #(.FAST_CYCLES(20), .UNIT_CYCLES(40)) dut (
		.clock_in(clock_in), .reset_in(reset_in),
		.avs_address_in(address), .avs_read_in(rd), .avs_write_in(wr),
		.avs_writedata_in(wdata), .avs_readdata_out(readdata),
		.avs_waitrequest_out(waitreq),
		.ambient_light_input_sample_in(smp),
		.ambient_light_input_valid_in(vld),
		.bank_a_target_out(ta), .bank_b_target_out(tb),
		.bank_c_target_out(tc), .applied_zone_out(az),
		.averaged_zone_out(vz));

	sensor_model sensor (.clock_in(clock_in), .level_in(level),
		.sample_out(smp), .valid_out(vld));

	// ****************************************************************
	// Helpers
	// ****************************************************************
	task check(input string name, input logic [31:0] got, exp);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask : check

	task test_done;
		$display("comparisons %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : test_done

	task cyc(input int n);
		repeat (n) @(posedge clock_in);
	endtask : cyc

	// One bus access; an idle edge follows so strobes never toggle twice
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		rd <= !w;
		wr <= w;
		address <= a;
		wdata <= d;
		do begin
			@(posedge clock_in);
			n++;
		end while (waitreq !== 1'b0 && n < 20);
		seen = readdata;
		rd <= 1'b0;
		wr <= 1'b0;
		@(posedge clock_in);
		if (n >= 20) begin
			fails++;
			test_done;
		end
	endtask : bus

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		repeat (5) @(posedge clock_in);
		reset_in <= 1'b0;
		@(posedge clock_in);
		check("applied zone", 32'(az), 32'h0);
		check("bank c target", 32'(tc), 32'(TARGET_RST[0]));
		bus(0, ADDR_CONFIG, 32'h0);
		check("config", seen, 32'h0);
		bus(0, ADDR_BND_HIGH, 32'h0);
		check("bound high", seen, 32'(BND_HIGH_RST[0]));
		bus(0, 8'h54, 32'h0);
		check("bank b target", seen, 32'(TARGET_RST[0]));
		bus(1, ADDR_STATUS, 32'hffff_ffff);
		bus(0, ADDR_STATUS, 32'h0);
		check("status", seen, 32'h0);
		bus(0, 8'h0c, 32'h0);
		check("unmapped", seen, UNMAPPED_DATA);
		$display("end of test registers");
		// Start-up with a zone 3 level; bank C zone 3 gets its own value
		bus(1, 8'h74, 32'h0000_005a);
		bus(1, ADDR_CONFIG, 32'h1);
		cyc(25);
		check("fast zone", 32'(vz), 32'h3);
		cyc(55);
		check("averaged", 32'(vz), 32'h3);
		check("applied", 32'(az), 32'h3);
		check("bank a", 32'(ta), 32'(TARGET_RST[3]));
		check("bank c", 32'(tc), 32'h5a);
		$display("end of test startup");
		// Rise to zone 4 in mid-period, direct algorithm
		level <= 8'hf0;
		cyc(120);
		check("averaged up", 32'(vz), 32'h4);
		check("not yet up", 32'(az), 32'h3);
		cyc(40);
		check("applied up", 32'(az), 32'h4);
		check("bank a up", 32'(ta), 32'(TARGET_RST[4]));
		$display("end of test direct");
		// Down-delay with code 2: eight periods downward
		bus(1, ADDR_DOWN_DELAY, 32'h2);
		bus(1, ADDR_CONFIG, 32'h3);
		cyc(34);
		level <= 8'h10;
		// Past the point where the direct rule would already have moved
		cyc(120);
		check("held at three", 32'(az), 32'h4);
		cyc(160);
		check("held at eight", 32'(az), 32'h4);
		cyc(40);
		check("applied down", 32'(az), 32'h0);
		check("bank a down", 32'(ta), 32'(TARGET_RST[0]));
		$display("end of test down delay");
		// Upward keeps the three-period rule, then a same-way follow
		level <= 8'h80;
		cyc(90);
		check("up not yet", 32'(az), 32'h0);
		level <= 8'hb0;
		cyc(20);
		check("up applied", 32'(az), 32'h2);
		cyc(40);
		check("follow up", 32'(az), 32'h3);
		check("bank b follow", 32'(tb), 32'(TARGET_RST[3]));
		$display("end of test follow");
		// Two periods down, then back up before the delay runs out
		level <= 8'h10;
		cyc(70);
		level <= 8'hb0;
		cyc(50);
		check("down abandoned", 32'(az), 32'h3);
		check("averaged back", 32'(vz), 32'h3);
		$display("end of test abandon");
		test_done;
	end
endmodule : tb_ambient_zone_backlight_decider

`default_nettype wire
